// ==== sdb_pkg.sv ====
// Shared constants and types for the synchronous DRAM device core.
package sdb_pkg;

  localparam int BANKS    = 4;
  localparam int ROWS     = 8192;
  localparam int COLS     = 1024;
  localparam int DW       = 16;
  localparam int BYTE_W   = 8;
  localparam int AW       = 13;
  localparam int BAW      = 2;
  localparam int CW       = 10;
  localparam int MW       = 12;
  localparam int MEM_AW   = 25;
  localparam int MEM_WORDS = BANKS * ROWS * COLS;
  localparam int DQM_W    = 2;
  localparam int PIN_W    = 4 + BAW + AW + DQM_W + DW;

  // Configuration field positions.
  localparam int BL_LSB    = 0;
  localparam int BL_MSB    = 2;
  localparam int ORDER_BIT = 3;
  localparam int CL_LSB    = 4;
  localparam int CL_MSB    = 6;
  localparam int WBM_BIT   = 9;

  // Address line that carries the auto precharge and all-banks select.
  localparam int AUTO_PRE_LINE = 10;

  localparam logic [MW-1:0]    CFG_RESET = 12'h000;
  localparam logic [PIN_W-1:0] PIN_IDLE  = 37'h1000000000;

  // Burst length and read latency codes.
  localparam logic [2:0] BL_1    = 3'h0;
  localparam logic [2:0] BL_2    = 3'h1;
  localparam logic [2:0] BL_4    = 3'h2;
  localparam logic [2:0] BL_8    = 3'h3;
  localparam logic [2:0] BL_FULL = 3'h7;
  localparam logic [2:0] CL_2    = 3'h2;
  localparam logic [2:0] CL_3    = 3'h3;

  // Wait loads for the read latency counter.
  localparam logic [1:0] WAIT_CL2 = 2'h1;
  localparam logic [1:0] WAIT_CL3 = 2'h2;

  // Command code is {chip select, row strobe, column strobe, write enable}.
  typedef enum logic [3:0] {
    CMD_LOAD_CFG = 4'h0,
    CMD_REFRESH  = 4'h1,
    CMD_PRECHG   = 4'h2,
    CMD_ACTIVATE = 4'h3,
    CMD_WRITE    = 4'h4,
    CMD_READ     = 4'h5,
    CMD_TERM     = 4'h6,
    CMD_NOP      = 4'h7,
    CMD_INHIBIT  = 4'h8
  } sdb_cmd_e;

  typedef enum logic [1:0] {
    ENG_IDLE  = 2'b00,
    ENG_WAIT  = 2'b01,
    ENG_BURST = 2'b11
  } sdb_eng_e;

endpackage : sdb_pkg

// ==== sdb_pair_buf.sv ====
// Two-entry valid/ready buffer on the read data path.
module sdb_pair_buf #(
  parameter int W = 16
) (
  // Clock and reset
  input  wire logic         core_clk_i,
  input  wire logic         arst_n_i,
  // Fill side
  input  wire logic         in_valid_i,
  output logic              in_ready_o,
  input  wire logic [W-1:0] in_data_i,
  // Drain side
  output logic              out_valid_o,
  input  wire logic         out_ready_i,
  output logic [W-1:0]      out_data_o
);

  logic [1:0]   count;
  logic [1:0]   next_count;
  logic [W-1:0] ent0;
  logic [W-1:0] ent1;
  logic [W-1:0] next_ent0;
  logic [W-1:0] next_ent1;
  logic         push;
  logic         pop;

  // No pass-through when full, so full is honest and the source stalls.
  assign in_ready_o  = (count != 2'h2);
  assign out_valid_o = (count != 2'h0);
  assign out_data_o  = ent0;
  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_o && out_ready_i;

  always_comb
  begin
    next_count = count;
    next_ent0  = ent0;
    next_ent1  = ent1;
    if (push && !pop)
    begin
      if (count == 2'h0)
        next_ent0 = in_data_i;
      else
        next_ent1 = in_data_i;
      next_count = count + 2'h1;
    end
    else if (pop && !push)
    begin
      next_ent0  = ent1;
      next_count = count - 2'h1;
    end
    else if (push && pop)
    begin
      if (count == 2'h1)
        next_ent0 = in_data_i;
      else
      begin
        next_ent0 = ent1;
        next_ent1 = in_data_i;
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      count <= 2'h0;
      ent0  <= '0;
      ent1  <= '0;
    end
    else
    begin
      count <= next_count;
      ent0  <= next_ent0;
      ent1  <= next_ent1;
    end
  end

  property p_buf_bound;
    @(posedge core_clk_i) disable iff (!arst_n_i)
    count <= 2'h2;
  endproperty
  a_buf_bound: assert property (p_buf_bound) else $error("buffer count above two");

  property p_buf_hold;
    @(posedge core_clk_i) disable iff (!arst_n_i)
    out_valid_o && !out_ready_i |=> out_valid_o && $stable(out_data_o);
  endproperty
  a_buf_hold: assert property (p_buf_hold) else $error("stalled word changed or lost");

endmodule : sdb_pair_buf

// ==== sdb_core.sv ====
// Synchronous DRAM device core: command decode, banks, configuration and bursts.
// Function
// RQ1: Every pin is registered on the rising clock edge before use.
// RQ2: Four banks of 8192 rows by 1024 columns of 16-bit words.
// RQ3: Activate opens a row; bank lines pick bank, 13 address lines pick row.
// RQ4: Low ten address lines of read or write give the starting column.
// RQ5: Controller idles at least 100 us after power and clock are stable.
// RQ6: Controller then precharges all banks, leaving every bank idle.
// RQ7: Controller performs two auto refreshes before loading configuration.
// RQ8: Configuration is undefined at power-up and must be loaded before use.
// RQ9: Configuration changes only by load command and holds otherwise.
// RQ10: Fields: length, order, latency, operating mode, write mode, reserved.
// RQ11: Controller drives the top address line low during configuration load.
// RQ12: Load only with all banks idle, then wait before next command.
// RQ13: Lengths 1, 2, 4, 8 for both orders; full page sequential only.
// RQ14: Full page plus burst terminate gives any burst length.
// RQ15: Upper column bits pick the block; low bits give start inside it.
// RQ16: A burst stays inside its block and wraps at the boundary.
// RQ17: Full page increments through the row and wraps to column zero.
// RQ18: Sequential adds step modulo length; interleaved XORs step into start.
// RQ19: Controller never programs reserved burst length codes.
// RQ20: A new column command may arrive every cycle during a burst.
// RQ21: One bank can precharge while another is accessed.
// RQ22: Auto precharge closes the row when its burst completes.
// RQ23: Read latency two or three; output enable rises one edge early.
// RQ24: Write mode bit one makes writes single-location, reads still burst.
// RQ25: Operating mode bits zero select normal operation.
// RQ26: Load takes the op-code from the low twelve address lines.
// RQ27: Length codes 0,1,2,3,7 and latency codes 2,3 as customary.
module sdb_core (
  // Clock and reset
  input  wire logic                        core_clk_i,
  input  wire logic                        arst_n_i,
  // Command pins
  input  wire logic                        cs_n_i,
  input  wire logic                        ras_n_i,
  input  wire logic                        cas_n_i,
  input  wire logic                        we_n_i,
  input  wire logic [sdb_pkg::BAW-1:0]     bank_select_i,
  input  wire logic [sdb_pkg::AW-1:0]      addr_i,
  // Data pins
  input  wire logic [sdb_pkg::DQM_W-1:0]   dqm_i,
  input  wire logic [sdb_pkg::DW-1:0]      dq_i,
  output logic      [sdb_pkg::DW-1:0]      dq_o,
  output logic                             dq_oe_o,
  // Read stream handshake
  input  wire logic                        rd_ready_i,
  output logic                             rd_valid_o,
  // Status
  output logic                             cfg_loaded_o,
  output logic                             burst_active_o,
  output logic      [sdb_pkg::BANKS-1:0]   bank_open_o
);

  import sdb_pkg::*;

  logic [PIN_W-1:0]  pin_meta;
  logic [PIN_W-1:0]  pin_sync;
  logic              cs_n_s;
  logic              ras_n_s;
  logic              cas_n_s;
  logic              we_n_s;
  logic [BAW-1:0]    ba_s;
  logic [AW-1:0]     addr_s;
  logic [DQM_W-1:0]  dqm_s;
  logic [DW-1:0]     dq_s;
  logic [DQM_W-1:0]  dqm_dly;
  logic [DW-1:0]     dq_dly;
  sdb_cmd_e          cmd;
  logic              cmd_idle;
  logic              rw_go;
  logic [BANKS-1:0]  ba_onehot;

  logic [MW-1:0]     cfg;
  logic [MW-1:0]     next_cfg;
  logic              cfg_loaded;
  logic              next_cfg_loaded;
  logic [2:0]        burst_length_field;
  logic              burst_order_bit;
  logic [2:0]        read_latency_field;
  logic              write_burst_mode_bit;

  logic [BANKS-1:0]  bank_open;
  logic [BANKS-1:0]  next_bank_open;
  logic [AW-1:0]     bank_row [BANKS];
  logic [AW-1:0]     next_bank_row [BANKS];

  sdb_eng_e          eng_state;
  sdb_eng_e          next_eng_state;
  logic [1:0]        wait_cnt;
  logic [1:0]        next_wait_cnt;
  logic [CW-1:0]     start_col;
  logic [CW-1:0]     next_start_col;
  logic [CW-1:0]     step;
  logic [CW-1:0]     next_step;
  logic [CW-1:0]     last_step;
  logic [CW-1:0]     next_last_step;
  logic [BAW-1:0]    eng_bank;
  logic [BAW-1:0]    next_eng_bank;
  logic              eng_read;
  logic              next_eng_read;
  logic              eng_ilv;
  logic              next_eng_ilv;
  logic              eng_autopre;
  logic              next_eng_autopre;
  logic              ap_close;
  logic              push;
  logic              fifo_in_ready;
  logic [CW-1:0]     cur_col;

  logic [DW-1:0]     mem [MEM_WORDS];
  logic [MEM_AW-1:0] mem_addr;
  logic              mem_we;
  logic [DW-1:0]     mem_rdata;
  logic [DW-1:0]     mem_wdata;

  // Block mask is the burst length minus one; it doubles as the last step.
  function automatic logic [CW-1:0] col_mask(input logic [2:0] code);
    case (code)
      BL_1:    col_mask = 10'h000;
      BL_2:    col_mask = 10'h001;
      BL_4:    col_mask = 10'h003;
      BL_8:    col_mask = 10'h007;
      BL_FULL: col_mask = 10'h3FF;
      default: col_mask = 10'h000;
    endcase
  endfunction : col_mask

  function automatic logic [CW-1:0] burst_col(input logic [CW-1:0] start,
                                               input logic [CW-1:0] k,
                                               input logic [CW-1:0] mask,
                                               input logic          ilv);
    logic [CW-1:0] off;
    off = ilv ? ((start ^ k) & mask) : ((start + k) & mask); // RQ18 RQ17
    burst_col = (start & ~mask) | off; // RQ15 RQ16
  endfunction : burst_col

  // Pins cross into the core through two flops; only the second is read.
  always_ff @(posedge core_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      pin_meta <= PIN_IDLE;
      pin_sync <= PIN_IDLE;
      dq_dly   <= '0;
      dqm_dly  <= '0;
    end
    else
    begin
      pin_meta <= {cs_n_i, ras_n_i, cas_n_i, we_n_i, bank_select_i, addr_i, dqm_i, dq_i}; // RQ1
      pin_sync <= pin_meta;
      dq_dly   <= dq_s;
      dqm_dly  <= dqm_s;
    end
  end

  assign {cs_n_s, ras_n_s, cas_n_s, we_n_s, ba_s, addr_s, dqm_s, dq_s} = pin_sync;
  assign cmd       = cs_n_s ? CMD_INHIBIT : sdb_cmd_e'({1'b0, ras_n_s, cas_n_s, we_n_s});
  assign cmd_idle  = (cmd == CMD_NOP) || (cmd == CMD_INHIBIT);
  assign rw_go     = ((cmd == CMD_READ) || (cmd == CMD_WRITE)) && bank_open[ba_s]; // RQ3
  assign ba_onehot = 4'h1 << ba_s;

  assign burst_length_field   = cfg[BL_MSB:BL_LSB]; // RQ10 RQ27
  assign burst_order_bit      = cfg[ORDER_BIT];
  assign read_latency_field   = cfg[CL_MSB:CL_LSB];
  assign write_burst_mode_bit = cfg[WBM_BIT];

  assign cur_col   = burst_col(start_col, step, last_step, eng_ilv);
  assign mem_addr  = {eng_bank, bank_row[eng_bank], cur_col}; // RQ2
  assign mem_rdata = mem[mem_addr];
  assign mem_wdata = {dqm_dly[1] ? mem_rdata[DW-1:BYTE_W] : dq_dly[DW-1:BYTE_W],
                      dqm_dly[0] ? mem_rdata[BYTE_W-1:0] : dq_dly[BYTE_W-1:0]};

  // Burst engine.
  always_comb
  begin
    next_eng_state   = eng_state;
    next_wait_cnt    = wait_cnt;
    next_start_col   = start_col;
    next_step        = step;
    next_last_step   = last_step;
    next_eng_bank    = eng_bank;
    next_eng_read    = eng_read;
    next_eng_ilv     = eng_ilv;
    next_eng_autopre = eng_autopre;
    ap_close         = 1'b0;
    push             = 1'b0;
    mem_we           = 1'b0;
    case (eng_state)
      ENG_WAIT:
      begin
        if (wait_cnt == 2'h1)
          next_eng_state = ENG_BURST;
        else
          next_wait_cnt = wait_cnt - 2'h1;
      end
      ENG_BURST:
      begin
        // Reads stall on a full buffer, so no word is dropped.
        if (!eng_read || fifo_in_ready)
        begin
          push   = eng_read;
          mem_we = !eng_read;
          if (step == last_step)
          begin
            next_eng_state = ENG_IDLE;
            ap_close       = eng_autopre; // RQ22
          end
          else
            next_step = step + 10'h001;
        end
      end
      default:
      begin
      end
    endcase
    if (rw_go)
    begin
      // A new column command cuts the running burst short.
      if (eng_state != ENG_IDLE)
        ap_close = eng_autopre; // RQ20
      next_start_col   = addr_s[CW-1:0]; // RQ4
      next_step        = 10'h000;
      next_eng_bank    = ba_s;
      next_eng_autopre = addr_s[AUTO_PRE_LINE];
      next_eng_ilv     = burst_order_bit && (burst_length_field != BL_FULL); // RQ13
      if (cmd == CMD_READ)
      begin
        next_eng_read  = 1'b1;
        next_last_step = col_mask(burst_length_field);
        next_eng_state = ENG_WAIT;
        next_wait_cnt  = (read_latency_field == CL_3) ? WAIT_CL3 : WAIT_CL2; // RQ23
      end
      else
      begin
        next_eng_read  = 1'b0;
        next_last_step = write_burst_mode_bit ? 10'h000 : col_mask(burst_length_field); // RQ24
        next_eng_state = ENG_BURST;
      end
    end
    else if (cmd == CMD_TERM)
      next_eng_state = ENG_IDLE; // RQ14
  end

  always_ff @(posedge core_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      eng_state   <= ENG_IDLE;
      wait_cnt    <= 2'h0;
      start_col   <= '0;
      step        <= '0;
      last_step   <= '0;
      eng_bank    <= '0;
      eng_read    <= 1'b0;
      eng_ilv     <= 1'b0;
      eng_autopre <= 1'b0;
    end
    else
    begin
      eng_state   <= next_eng_state;
      wait_cnt    <= next_wait_cnt;
      start_col   <= next_start_col;
      step        <= next_step;
      last_step   <= next_last_step;
      eng_bank    <= next_eng_bank;
      eng_read    <= next_eng_read;
      eng_ilv     <= next_eng_ilv;
      eng_autopre <= next_eng_autopre;
    end
  end

  // Banks and configuration.
  always_comb
  begin
    next_bank_open  = bank_open;
    next_bank_row   = bank_row;
    next_cfg        = cfg;
    next_cfg_loaded = cfg_loaded;
    if (ap_close)
      next_bank_open[eng_bank] = 1'b0; // RQ22
    case (cmd)
      CMD_ACTIVATE:
      begin
        if (!bank_open[ba_s])
        begin
          next_bank_open[ba_s] = 1'b1; // RQ3
          next_bank_row[ba_s]  = addr_s;
        end
      end
      CMD_PRECHG:
      begin
        if (addr_s[AUTO_PRE_LINE])
          next_bank_open = '0;
        else
          next_bank_open[ba_s] = 1'b0; // RQ21
      end
      CMD_LOAD_CFG:
      begin
        // A load while any bank is open is dropped rather than half-applied.
        if ((bank_open == '0) && (eng_state == ENG_IDLE)) // RQ12
        begin
          next_cfg        = addr_s[MW-1:0]; // RQ9 RQ26
          next_cfg_loaded = 1'b1; // RQ8
        end
      end
      default:
      begin
      end
    endcase
  end

  always_ff @(posedge core_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      bank_open  <= '0;
      bank_row   <= '{default: '0};
      cfg        <= CFG_RESET;
      cfg_loaded <= 1'b0;
    end
    else
    begin
      bank_open  <= next_bank_open;
      bank_row   <= next_bank_row;
      cfg        <= next_cfg;
      cfg_loaded <= next_cfg_loaded;
    end
  end

  always_ff @(posedge core_clk_i)
  begin
    if (mem_we)
      mem[mem_addr] <= mem_wdata;
  end

  sdb_pair_buf #(
    .W (DW)
  ) u_rd_buf (
    .core_clk_i  (core_clk_i),
    .arst_n_i    (arst_n_i),
    .in_valid_i  (push),
    .in_ready_o  (fifo_in_ready),
    .in_data_i   (mem_rdata),
    .out_valid_o (rd_valid_o),
    .out_ready_i (rd_ready_i),
    .out_data_o  (dq_o)
  );

  assign dq_oe_o        = rd_valid_o || ((eng_state == ENG_BURST) && eng_read); // RQ23
  assign cfg_loaded_o   = cfg_loaded;
  assign burst_active_o = (eng_state != ENG_IDLE);
  assign bank_open_o    = bank_open;

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!arst_n_i);

  sequence s_wait_burst;
    eng_state == ENG_WAIT ##1 eng_state == ENG_BURST;
  endsequence

  property p_cl2;
    (rw_go && cmd == CMD_READ && read_latency_field == CL_2) ##1 cmd_idle |-> s_wait_burst;
  endproperty
  a_cl2: assert property (p_cl2) else $error("latency two start wrong"); // RQ23

  property p_cl3;
    (rw_go && cmd == CMD_READ && read_latency_field == CL_3) ##1 cmd_idle [*2]
      |-> s_wait_burst;
  endproperty
  a_cl3: assert property (p_cl3) else $error("latency three start wrong"); // RQ23

  property p_in_block;
    eng_state == ENG_BURST |-> (cur_col & ~last_step) == (start_col & ~last_step);
  endproperty
  a_in_block: assert property (p_in_block) else $error("burst left its block"); // RQ16

  property p_ilv;
    eng_state == ENG_BURST && eng_ilv |-> (cur_col & last_step) == ((start_col ^ step) & last_step);
  endproperty
  a_ilv: assert property (p_ilv) else $error("interleaved order wrong"); // RQ18

  property p_restart;
    rw_go |=> step == 10'h000 && start_col == $past(addr_s[CW-1:0]) && eng_state != ENG_IDLE;
  endproperty
  a_restart: assert property (p_restart) else $error("column command not taken"); // RQ20

  property p_cfg_load;
    cmd == CMD_LOAD_CFG && bank_open == '0 && eng_state == ENG_IDLE
      |=> cfg == $past(addr_s[MW-1:0]) && cfg_loaded;
  endproperty
  a_cfg_load: assert property (p_cfg_load) else $error("configuration not loaded"); // RQ26

  property p_cfg_hold;
    cmd != CMD_LOAD_CFG |=> $stable(cfg);
  endproperty
  a_cfg_hold: assert property (p_cfg_hold) else $error("configuration changed"); // RQ9

  property p_act;
    cmd == CMD_ACTIVATE && !bank_open[ba_s]
      |=> bank_open[$past(ba_s)] && bank_row[$past(ba_s)] == $past(addr_s);
  endproperty
  a_act: assert property (p_act) else $error("row not opened"); // RQ3

  property p_pre_one;
    cmd == CMD_PRECHG && !addr_s[AUTO_PRE_LINE] && !ap_close
      |=> bank_open == ($past(bank_open) & ~$past(ba_onehot));
  endproperty
  a_pre_one: assert property (p_pre_one) else $error("precharge hit other bank"); // RQ21

  property p_autopre;
    ap_close && cmd != CMD_ACTIVATE |=> !bank_open[$past(eng_bank)];
  endproperty
  a_autopre: assert property (p_autopre) else $error("auto precharge missed"); // RQ22

  property p_wbm;
    (rw_go && cmd == CMD_WRITE && write_burst_mode_bit) ##1 cmd_idle |=> eng_state == ENG_IDLE;
  endproperty
  a_wbm: assert property (p_wbm) else $error("write not single location"); // RQ24

  property p_term;
    cmd == CMD_TERM |=> eng_state == ENG_IDLE;
  endproperty
  a_term: assert property (p_term) else $error("terminate ignored"); // RQ14

endmodule : sdb_core

// ==== sdb_ctrl_model.sv ====
// Controller model that drives the command, address and write data pins.
module sdb_ctrl_model #(
  parameter int PWRUP_CYC = 20000
) (
  // Clock
  input  wire logic                    core_clk_i,
  // Command and data pins
  output logic                         cs_n_o,
  output logic                         ras_n_o,
  output logic                         cas_n_o,
  output logic                         we_n_o,
  output logic [sdb_pkg::BAW-1:0]      bank_o,
  output logic [sdb_pkg::AW-1:0]       addr_o,
  output logic [sdb_pkg::DW-1:0]       dq_o
);
  timeunit 1ns;
  timeprecision 1ps;
  import sdb_pkg::*;

  initial
  begin
    {cs_n_o, ras_n_o, cas_n_o, we_n_o} = CMD_INHIBIT;
    bank_o = 2'h0;
    addr_o = 13'h0000;
    dq_o = 16'h0000;
  end

  task automatic cmd(input logic [3:0] c, input logic [BAW-1:0] b,
                     input logic [AW-1:0] a, input logic [DW-1:0] d);
    @(posedge core_clk_i);
    {cs_n_o, ras_n_o, cas_n_o, we_n_o} <= c;
    bank_o <= b;
    addr_o <= a;
    dq_o <= d;
  endtask : cmd

  // Deselected cycles toggle the bank, address and data lines so stale values are never trusted.
  task automatic idle(input int n);
    repeat (n) cmd(CMD_INHIBIT, ~bank_o, ~addr_o, ~dq_o);
  endtask : idle

  task automatic power_up();
    repeat (PWRUP_CYC) cmd(CMD_NOP, 2'h0, 13'h0000, 16'h0000);
    cmd(CMD_PRECHG, 2'h0, 13'h0400, 16'h0000);
    repeat (2) cmd(CMD_REFRESH, 2'h0, 13'h0000, 16'h0000);
  endtask : power_up

  // Callers load only with every bank closed and a legal length code.
  task automatic load(input logic [MW-1:0] op);
    cmd(CMD_LOAD_CFG, 2'h0, {1'b0, op}, 16'h0000);
    idle(2);
  endtask : load
endmodule : sdb_ctrl_model

// ==== tb_sdb_core.sv ====
// Self-checking testbench for the synchronous DRAM device core.
module tb_sdb_core;
  timeunit 1ns;
  timeprecision 1ps;
  import sdb_pkg::*;

  logic            clk;
  logic            arst_n;
  logic            cs_n;
  logic            ras_n;
  logic            cas_n;
  logic            we_n;
  logic [BAW-1:0]  bank;
  logic [AW-1:0]   addr;
  logic [DW-1:0]   dq_drv;
  logic [DW-1:0]   dq_out;
  logic            dq_oe;
  logic            rd_ready = 1'b0;
  logic            rd_valid;
  logic            cfg_loaded;
  logic            burst_active;
  logic [BANKS-1:0] bank_open;
  logic [DW-1:0]   mem [BANKS][8];
  logic [DW-1:0]   exp_q [$];
  int              err_count = 0;
  int              n_checks = 0;
  int              seed = 32'h79EE;
  int              stall_cnt = 0;
  logic [AW-1:0]   rows [BANKS];
  logic [DW-1:0]   page_word [4];
  logic            ready_hold = 1'b0;

  sdb_ctrl_model ctl (.core_clk_i(clk), .cs_n_o(cs_n), .ras_n_o(ras_n), .cas_n_o(cas_n),
    .we_n_o(we_n), .bank_o(bank), .addr_o(addr), .dq_o(dq_drv));

  sdb_core uut (.core_clk_i(clk), .arst_n_i(arst_n), .cs_n_i(cs_n), .ras_n_i(ras_n),
    .cas_n_i(cas_n), .we_n_i(we_n), .bank_select_i(bank), .addr_i(addr),
    .dqm_i(2'h0), .dq_i(dq_drv), .dq_o(dq_out), .dq_oe_o(dq_oe), .rd_ready_i(rd_ready),
    .rd_valid_o(rd_valid), .cfg_loaded_o(cfg_loaded), .burst_active_o(burst_active),
    .bank_open_o(bank_open));

  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  initial
  begin
    arst_n = 1'b0;
    repeat (8) @(posedge clk);
    arst_n <= 1'b1;
  end

  // Long stalls force the two-entry buffer full before it drains.
  always @(posedge clk)
  begin
    rd_ready <= ready_hold || ((stall_cnt == 0) && (($random(seed) & 3) != 0));
    if (stall_cnt > 0)
      stall_cnt <= stall_cnt - 1;
  end

  task automatic chk(input string what, input logic [DW-1:0] e, input logic [DW-1:0] s);
    n_checks++;
    if (s !== e)
    begin
      err_count++;
      $display("wrong value %s expected %h seen %h", what, e, s);
    end
  endtask : chk

  always @(posedge clk)
    if (rd_valid === 1'b1 && rd_ready === 1'b1)
    begin
      if (exp_q.size() == 0)
        chk("word count", 16'h0000, 16'h0001);
      else
        chk("read word", exp_q.pop_front(), dq_out);
    end

  function automatic logic [CW-1:0] col_at(input logic [CW-1:0] s, input int k,
                                           input int len, input logic ilv);
    logic [CW-1:0] m;
    m = CW'(len - 1);
    return (s & ~m) | ((ilv ? (s ^ CW'(k)) : (s + CW'(k))) & m);
  endfunction : col_at

  task automatic access(input int bi, input int len, input logic ilv, input int cl,
                        input logic wbm);
    logic [CW-1:0] c;
    logic [DW-1:0] d;
    ctl.load({2'h0, wbm, 2'h0, 3'(cl), ilv, 3'($clog2(len))});
    ctl.cmd(CMD_ACTIVATE, 2'(bi), rows[bi], 16'h0000);
    ctl.idle(3);
    #1;
    chk("bank open", 16'(4'h1 << bi), 16'(bank_open));
    c = 10'($random(seed)) & 10'h007;
    for (int k = 0; k < (wbm ? 1 : len); k++)
    begin
      d = 16'($random(seed));
      mem[bi][3'(col_at(c, k, len, ilv))] = d;
      if (k == 0)
        ctl.cmd(CMD_WRITE, 2'(bi), {3'h0, c}, d);
      else
        ctl.cmd(CMD_NOP, 2'(bi), 13'h0000, d);
    end
    ctl.idle(len + 3);
    c = 10'($random(seed)) & 10'h007;
    for (int k = 0; k < len; k++)
      exp_q.push_back(mem[bi][3'(col_at(c, k, len, ilv))]);
    if (len == 8)
      stall_cnt = 20;
    ctl.cmd(CMD_READ, 2'(bi), {3'h1, c}, 16'h0000);
    for (int n = 1; n <= cl + 3; n++)
    begin
      ctl.idle(1);
      #1;
      if (n == cl + 2)
        chk("early drive", 16'h0002, 16'({dq_oe, rd_valid}));
      if (n == cl + 3)
        chk("first word", 16'h0001, 16'(rd_valid));
    end
    for (int t = 0; t < 80 && (exp_q.size() > 0 || burst_active !== 1'b0); t++)
      ctl.idle(1);
    ctl.idle(3);
    #1;
    chk("words left", 16'h0000, 16'(exp_q.size()));
    chk("auto close", 16'h0000, 16'(bank_open));
  endtask : access

  task automatic conclude();
    if (err_count == 0 && n_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : conclude

  // One row per bank for the whole run, so columns written earlier stay readable.
  initial
  begin
    foreach (rows[b])
      rows[b] = 13'($random(seed));
    ctl.power_up();
    #1;
    chk("config flag", 16'h0000, 16'(cfg_loaded));
    for (int b = 0; b < BANKS; b++)
      access(b, 8, 1'b0, 2, 1'b0);
    chk("config flag", 16'h0001, 16'(cfg_loaded));
    // Every length with both orders and both latencies, one single-write case.
    for (int i = 0; i < 16; i++)
      access((i + i / 4) % 4, 1 << (i % 4), i[2], i[3] ? 3 : 2, i == 6);
    // Full page ignores the order bit and wraps past the last column; terminate ends it.
    ctl.load(12'h02F);
    ctl.cmd(CMD_ACTIVATE, 2'h0, rows[0], 16'h0000);
    ctl.cmd(CMD_ACTIVATE, 2'h1, rows[1], 16'h0000);
    ctl.idle(3);
    #1;
    chk("bank open", 16'h0003, 16'(bank_open));
    for (int k = 0; k < 4; k++)
    begin
      page_word[k] = 16'($random(seed));
      if (k == 0)
        ctl.cmd(CMD_WRITE, 2'h0, 13'h03FE, page_word[k]);
      else if (k == 2)
        ctl.cmd(CMD_PRECHG, 2'h1, 13'h0000, page_word[k]);
      else
        ctl.cmd(CMD_NOP, 2'h0, 13'h0000, page_word[k]);
    end
    ctl.cmd(CMD_TERM, 2'h0, 13'h0000, 16'h0000);
    ctl.idle(3);
    #1;
    chk("bank open", 16'h0001, 16'(bank_open));
    chk("burst idle", 16'h0000, 16'(burst_active));
    exp_q.push_back(page_word[1]);
    exp_q.push_back(page_word[2]);
    exp_q.push_back(page_word[3]);
    exp_q.push_back(mem[0][2]);
    // The receiver never stalls here, so the terminate lands after exactly four words.
    ready_hold = 1'b1;
    ctl.cmd(CMD_READ, 2'h0, 13'h03FF, 16'h0000);
    ctl.idle(4);
    #1;
    chk("burst busy", 16'h0001, 16'(burst_active));
    ctl.cmd(CMD_TERM, 2'h0, 13'h0000, 16'h0000);
    ctl.idle(6);
    #1;
    chk("words left", 16'h0000, 16'(exp_q.size()));
    chk("burst idle", 16'h0000, 16'(burst_active));
    ctl.cmd(CMD_PRECHG, 2'h0, 13'h0000, 16'h0000);
    ctl.idle(3);
    #1;
    chk("bank open", 16'h0000, 16'(bank_open));
    conclude();
  end

  // The run needs about 105 us; the 250 us limit, over twice that, means a hang.
  initial
  begin
    #250000;
    err_count++;
    conclude();
  end
endmodule : tb_sdb_core
